// File: synth_divider_config_pkg.sv
// How it works
// - Offset 22h bits 2..0: divider top bits
// - Offset 24h: divider low sixteen bits
// - Offset 26h: denominator upper half, all ones
// - Offset 27h: denominator lower half, all ones
// - Offset 2Ah: numerator upper half, zero
// - Offset 2Bh: numerator lower half, zero
// - Offset 28h: seed upper half, zero
// - Offset 29h: seed lower half, zero
// - Seed loads as accumulator starting state
// - Seed used only when 25h bit15 set
// - Soft reset restores fixed registers 1Fh-21h and 23h
package synth_divider_config_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int REG_FIRST = 30;
    localparam int REG_COUNT = 14;

    localparam logic [5:0] OFS_SOFT_RESET = 6'h00;
    localparam logic [5:0] OFS_FIXED_1E = 6'h1e;
    localparam logic [5:0] OFS_FIXED_1F = 6'h1f;
    localparam logic [5:0] OFS_FIXED_20 = 6'h20;
    localparam logic [5:0] OFS_FIXED_21 = 6'h21;
    localparam logic [5:0] OFS_DIV_HIGH = 6'h22;
    localparam logic [5:0] OFS_FIXED_23 = 6'h23;
    localparam logic [5:0] OFS_DIV_LOW = 6'h24;
    localparam logic [5:0] OFS_SEED_EN_DLY = 6'h25;
    localparam logic [5:0] OFS_DEN_HIGH = 6'h26;
    localparam logic [5:0] OFS_DEN_LOW = 6'h27;
    localparam logic [5:0] OFS_SEED_HIGH = 6'h28;
    localparam logic [5:0] OFS_SEED_LOW = 6'h29;
    localparam logic [5:0] OFS_NUM_HIGH = 6'h2a;
    localparam logic [5:0] OFS_NUM_LOW = 6'h2b;

    localparam int SOFT_RESET_BIT = 1;
    localparam int DIV_HIGH_MSB = 2;
    localparam int SEED_EN_BIT = 15;
    localparam int DLY_MSB = 13;
    localparam int DLY_LSB = 8;

    localparam logic [15:0] RST_FIXED_1E = 16'h18c6;
    localparam logic [15:0] RST_FIXED_1F = 16'hc3e6;
    localparam logic [15:0] RST_FIXED_20 = 16'h05bf;
    localparam logic [15:0] RST_FIXED_21 = 16'h1e01;
    localparam logic [15:0] RST_DIV_HIGH = 16'h0010;
    localparam logic [15:0] RST_FIXED_23 = 16'h0004;
    localparam logic [15:0] RST_DIV_LOW = 16'h0028;
    localparam logic [15:0] RST_SEED_EN_DLY = 16'h0205;
    localparam logic [15:0] RST_DEN = 16'hffff;
    localparam logic [15:0] RST_ZERO = 16'h0000;
endpackage : synth_divider_config_pkg

// File: frac_seed_accum.sv
`timescale 1ns/100ps
// Fractional accumulator; state restarts from seed or zero on load
module frac_seed_accum #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic seed_en_i,
    input wire logic [WIDTH-1:0] seed_i,
    input wire logic [WIDTH-1:0] num_i,
    input wire logic [WIDTH-1:0] den_i,
    output logic [WIDTH-1:0] acc_o,
    output logic carry_o
);
    if (WIDTH < 2) begin : g_width_check
        $error("WIDTH too small");
    end

    logic [WIDTH:0] sum;
    logic [WIDTH:0] wrapped;

    always_comb begin
        sum = {1'b0, acc_o} + {1'b0, num_i};
        wrapped = sum - {1'b0, den_i};
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_o <= '0;
            carry_o <= 1'b0;
        end else if (load_i) begin
            acc_o <= seed_en_i ? seed_i : '0;
            carry_o <= 1'b0;
        end else if (sum >= {1'b0, den_i}) begin
            acc_o <= wrapped[WIDTH-1:0];
            carry_o <= 1'b1;
        end else begin
            acc_o <= sum[WIDTH-1:0];
            carry_o <= 1'b0;
        end
    end
endmodule : frac_seed_accum

// File: synth_divider_config_regs.sv
`timescale 1ns/100ps
module synth_divider_config_regs (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [5:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic [18:0] feedback_divider_o,
    output logic [31:0] frac_denominator_o,
    output logic [31:0] frac_numerator_o,
    output logic [31:0] modulator_seed_o,
    output logic modulator_seed_enable_o,
    output logic [5:0] phase_detector_delay_select_o,
    output logic [31:0] frac_accum_o,
    output logic frac_carry_o
);
    logic [15:0] fixed_cfg_at_1e;
    logic [15:0] fixed_cfg_at_1f;
    logic [15:0] fixed_cfg_at_20;
    logic [15:0] fixed_cfg_at_21;
    logic [15:0] feedback_divider_high;
    logic [15:0] fixed_cfg_at_23;
    logic [15:0] feedback_divider_low;
    logic [15:0] seed_enable_and_pfd_delay;
    logic [15:0] frac_denominator_high;
    logic [15:0] frac_denominator_low;
    logic [15:0] modulator_seed_high;
    logic [15:0] modulator_seed_low;
    logic [15:0] frac_numerator_high;
    logic [15:0] frac_numerator_low;
    logic soft_reset;
    logic accum_load;
    logic [15:0] next_rdata;
    logic [31:0] accum_q;
    logic carry_q;

    function automatic logic wr_hit(input logic [5:0] a);
        return wr_i && (addr_i == a);
    endfunction : wr_hit

    // Soft reset bit in register zero; not stored, acts as a strobe
    always_comb begin
        soft_reset = wr_hit(synth_divider_config_pkg::OFS_SOFT_RESET)
            && wdata_i[synth_divider_config_pkg::SOFT_RESET_BIT];
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fixed_cfg_at_1e <= synth_divider_config_pkg::RST_FIXED_1E;
        end else if (wr_hit(synth_divider_config_pkg::OFS_FIXED_1E)) begin
            fixed_cfg_at_1e <= wdata_i;
        end
    end

    // Fixed registers 1Fh-21h and 23h: soft reset restores them, so software may skip rewriting
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fixed_cfg_at_1f <= synth_divider_config_pkg::RST_FIXED_1F;
            fixed_cfg_at_20 <= synth_divider_config_pkg::RST_FIXED_20;
            fixed_cfg_at_21 <= synth_divider_config_pkg::RST_FIXED_21;
            fixed_cfg_at_23 <= synth_divider_config_pkg::RST_FIXED_23;
        end else if (soft_reset) begin
            fixed_cfg_at_1f <= synth_divider_config_pkg::RST_FIXED_1F;
            fixed_cfg_at_20 <= synth_divider_config_pkg::RST_FIXED_20;
            fixed_cfg_at_21 <= synth_divider_config_pkg::RST_FIXED_21;
            fixed_cfg_at_23 <= synth_divider_config_pkg::RST_FIXED_23;
        end else begin
            if (wr_hit(synth_divider_config_pkg::OFS_FIXED_1F)) begin
                fixed_cfg_at_1f <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_FIXED_20)) begin
                fixed_cfg_at_20 <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_FIXED_21)) begin
                fixed_cfg_at_21 <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_FIXED_23)) begin
                fixed_cfg_at_23 <= wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            feedback_divider_high <= synth_divider_config_pkg::RST_DIV_HIGH;
            feedback_divider_low <= synth_divider_config_pkg::RST_DIV_LOW;
        end else begin
            if (wr_hit(synth_divider_config_pkg::OFS_DIV_HIGH)) begin
                feedback_divider_high <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_DIV_LOW)) begin
                feedback_divider_low <= wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seed_enable_and_pfd_delay <= synth_divider_config_pkg::RST_SEED_EN_DLY;
        end else if (wr_hit(synth_divider_config_pkg::OFS_SEED_EN_DLY)) begin
            seed_enable_and_pfd_delay <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frac_denominator_high <= synth_divider_config_pkg::RST_DEN;
            frac_denominator_low <= synth_divider_config_pkg::RST_DEN;
            frac_numerator_high <= synth_divider_config_pkg::RST_ZERO;
            frac_numerator_low <= synth_divider_config_pkg::RST_ZERO;
        end else begin
            if (wr_hit(synth_divider_config_pkg::OFS_DEN_HIGH)) begin
                frac_denominator_high <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_DEN_LOW)) begin
                frac_denominator_low <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_NUM_HIGH)) begin
                frac_numerator_high <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_NUM_LOW)) begin
                frac_numerator_low <= wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            modulator_seed_high <= synth_divider_config_pkg::RST_ZERO;
            modulator_seed_low <= synth_divider_config_pkg::RST_ZERO;
        end else begin
            if (wr_hit(synth_divider_config_pkg::OFS_SEED_HIGH)) begin
                modulator_seed_high <= wdata_i;
            end
            if (wr_hit(synth_divider_config_pkg::OFS_SEED_LOW)) begin
                modulator_seed_low <= wdata_i;
            end
        end
    end

    // Restart the accumulator on any write that changes its inputs
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            accum_load <= 1'b1;
        end else begin
            accum_load <= soft_reset
                || wr_hit(synth_divider_config_pkg::OFS_SEED_EN_DLY)
                || wr_hit(synth_divider_config_pkg::OFS_SEED_HIGH)
                || wr_hit(synth_divider_config_pkg::OFS_SEED_LOW)
                || wr_hit(synth_divider_config_pkg::OFS_NUM_HIGH)
                || wr_hit(synth_divider_config_pkg::OFS_NUM_LOW)
                || wr_hit(synth_divider_config_pkg::OFS_DEN_HIGH)
                || wr_hit(synth_divider_config_pkg::OFS_DEN_LOW);
        end
    end

    frac_seed_accum #(
        .WIDTH(32)
    ) i_frac_seed_accum (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .load_i(accum_load),
        .seed_en_i(seed_enable_and_pfd_delay[synth_divider_config_pkg::SEED_EN_BIT]),
        .seed_i({modulator_seed_high, modulator_seed_low}),
        .num_i({frac_numerator_high, frac_numerator_low}),
        .den_i({frac_denominator_high, frac_denominator_low}),
        .acc_o(accum_q),
        .carry_o(carry_q)
    );

    always_comb begin
        case (addr_i)
            synth_divider_config_pkg::OFS_FIXED_1E: next_rdata = fixed_cfg_at_1e;
            synth_divider_config_pkg::OFS_FIXED_1F: next_rdata = fixed_cfg_at_1f;
            synth_divider_config_pkg::OFS_FIXED_20: next_rdata = fixed_cfg_at_20;
            synth_divider_config_pkg::OFS_FIXED_21: next_rdata = fixed_cfg_at_21;
            synth_divider_config_pkg::OFS_DIV_HIGH: next_rdata = feedback_divider_high;
            synth_divider_config_pkg::OFS_FIXED_23: next_rdata = fixed_cfg_at_23;
            synth_divider_config_pkg::OFS_DIV_LOW: next_rdata = feedback_divider_low;
            synth_divider_config_pkg::OFS_SEED_EN_DLY: next_rdata = seed_enable_and_pfd_delay;
            synth_divider_config_pkg::OFS_DEN_HIGH: next_rdata = frac_denominator_high;
            synth_divider_config_pkg::OFS_DEN_LOW: next_rdata = frac_denominator_low;
            synth_divider_config_pkg::OFS_SEED_HIGH: next_rdata = modulator_seed_high;
            synth_divider_config_pkg::OFS_SEED_LOW: next_rdata = modulator_seed_low;
            synth_divider_config_pkg::OFS_NUM_HIGH: next_rdata = frac_numerator_high;
            synth_divider_config_pkg::OFS_NUM_LOW: next_rdata = frac_numerator_low;
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // Registered copies so every output comes from a flop
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            feedback_divider_o <= '0;
            frac_denominator_o <= '0;
            frac_numerator_o <= '0;
            modulator_seed_o <= '0;
            modulator_seed_enable_o <= 1'b0;
            phase_detector_delay_select_o <= '0;
        end else begin
            feedback_divider_o <= {feedback_divider_high[synth_divider_config_pkg::DIV_HIGH_MSB:0],
                feedback_divider_low};
            frac_denominator_o <= {frac_denominator_high, frac_denominator_low};
            frac_numerator_o <= {frac_numerator_high, frac_numerator_low};
            modulator_seed_o <= {modulator_seed_high, modulator_seed_low};
            modulator_seed_enable_o <=
                seed_enable_and_pfd_delay[synth_divider_config_pkg::SEED_EN_BIT];
            phase_detector_delay_select_o <= seed_enable_and_pfd_delay[
                synth_divider_config_pkg::DLY_MSB:synth_divider_config_pkg::DLY_LSB];
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frac_accum_o <= '0;
            frac_carry_o <= 1'b0;
        end else begin
            frac_accum_o <= accum_q;
            frac_carry_o <= carry_q;
        end
    end
endmodule : synth_divider_config_regs

// File: synth_divider_config_regs_assertions.sv
`timescale 1ns/100ps
module synth_divider_config_regs_assertions (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [5:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [18:0] feedback_divider_o,
    input wire logic [31:0] frac_denominator_o,
    input wire logic [31:0] frac_numerator_o,
    input wire logic [31:0] modulator_seed_o,
    input wire logic modulator_seed_enable_o,
    input wire logic [31:0] frac_accum_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_soft_reset;
        wr_i && addr_i == 6'h00 && wdata_i[1];
    endsequence
    sequence s_wr_then_rd;
        wr_i && addr_i >= 6'h1e && addr_i <= 6'h2b ##1 rd_i && $stable(addr_i);
    endsequence
    // Mirrors lag the register by one cycle, so two after the write
    property p_mirror(logic [5:0] ofs, logic [15:0] half);
        wr_i && addr_i == ofs |-> ##2 half == $past(wdata_i, 2);
    endproperty
    a_div_low: assert property (p_mirror(6'h24, feedback_divider_o[15:0]))
        else $error("divider low half not mirrored");
    a_div_high: assert property (wr_i && addr_i == 6'h22 |-> ##2
        feedback_divider_o[18:16] == $past(wdata_i[2:0], 2)) else $error("divider top bits wrong");
    a_den_high: assert property (p_mirror(6'h26, frac_denominator_o[31:16]))
        else $error("denominator high wrong");
    a_den_low: assert property (p_mirror(6'h27, frac_denominator_o[15:0]))
        else $error("denominator low wrong");
    a_num_high: assert property (p_mirror(6'h2a, frac_numerator_o[31:16]))
        else $error("numerator high wrong");
    a_num_low: assert property (p_mirror(6'h2b, frac_numerator_o[15:0]))
        else $error("numerator low wrong");
    a_seed_high: assert property (p_mirror(6'h28, modulator_seed_o[31:16]))
        else $error("seed high wrong");
    a_seed_low: assert property (p_mirror(6'h29, modulator_seed_o[15:0]))
        else $error("seed low wrong");
    a_seed_enable: assert property (wr_i && addr_i == 6'h25 |-> ##2
        modulator_seed_enable_o == $past(wdata_i[15], 2)) else $error("seed enable wrong");
    a_seed_load: assert property (wr_i && addr_i == 6'h25 && wdata_i[15] |-> ##[2:3]
        frac_accum_o == modulator_seed_o) else $error("seed not loaded");
    a_seed_off: assert property (wr_i && addr_i == 6'h25 && !wdata_i[15] |-> ##[2:3]
        frac_accum_o == 32'h0000_0000) else $error("disabled seed still loaded");
    a_read_back: assert property (s_wr_then_rd |=> rdata_o == $past(wdata_i, 2))
        else $error("read does not return written value");
    a_soft_restore: assert property (s_soft_reset ##1 rd_i && addr_i == 6'h1f |=>
        rdata_o == 16'hc3e6) else $error("soft reset did not restore");
endmodule : synth_divider_config_regs_assertions

bind synth_divider_config_regs synth_divider_config_regs_assertions i_checker (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .feedback_divider_o(feedback_divider_o),
    .frac_denominator_o(frac_denominator_o), .frac_numerator_o(frac_numerator_o),
    .modulator_seed_o(modulator_seed_o), .modulator_seed_enable_o(modulator_seed_enable_o),
    .frac_accum_o(frac_accum_o));

// File: synth_divider_config_regs_test.sv
`timescale 1ns/100ps
module synth_divider_config_regs_test;
    logic core_clk_i, nrst_i, wr_i, rd_i, seed_en, carry;
    logic [5:0] addr_i, dly;
    logic [15:0] wdata_i, rdata_o;
    logic [18:0] fdiv;
    logic [31:0] den, num, seed, acc;
    int error_cnt, comparisons, cycles;
    logic [31:0] win_acc, win_carry;
    localparam logic [15:0] RST_TAB [14] = '{16'h18c6, 16'hc3e6, 16'h05bf, 16'h1e01,
        16'h0010, 16'h0004, 16'h0028, 16'h0205, 16'hffff, 16'hffff, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};

    synth_divider_config_regs i_synth_divider_config_regs (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .feedback_divider_o(fdiv), .frac_denominator_o(den),
        .frac_numerator_o(num), .modulator_seed_o(seed), .modulator_seed_enable_o(seed_en),
        .phase_detector_delay_select_o(dly), .frac_accum_o(acc), .frac_carry_o(carry));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // Distinct per offset, bit 15 set and delay field equal to the offset
    function automatic logic [15:0] pat(input logic [5:0] a);
        return {2'b10, a, 2'b01, a};
    endfunction : pat

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
    endtask : wr

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
        #1;
    endtask : idle

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        check(32'(rdata_o), 32'(exp));
    endtask : rd

    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        nrst_i <= 1'b1;
    endtask : do_reset

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        nrst_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 6'h00;
        wdata_i = 16'h0000;
        win_acc = 32'h0000_0000;
        win_carry = 32'h0000_0000;
        do_reset();
        for (int i = 0; i < 14; i++) rd(6'(30 + i), RST_TAB[i]);
        rd(6'h2c, 16'h0000);
        check(32'(fdiv), 32'h0000_0028);
        check(den, 32'hffff_ffff);
        check(num | seed, 32'h0000_0000);
        check(32'({seed_en, dly}), 32'h0000_0002);
        for (int i = 0; i < 14; i++) wr(6'(30 + i), pat(6'(30 + i)));
        wr(6'h2c, 16'hdead);
        for (int i = 0; i < 14; i++) rd(6'(30 + i), pat(6'(30 + i)));
        rd(6'h2c, 16'h0000);
        check(32'(fdiv), 32'({pat(6'h22) & 16'h0007, pat(6'h24)}));
        check(den, {pat(6'h26), pat(6'h27)});
        check(num, {pat(6'h2a), pat(6'h2b)});
        check(seed, {pat(6'h28), pat(6'h29)});
        check(32'({seed_en, dly}), 32'h0000_0065);
        wr(6'h2a, 16'h0000);
        wr(6'h2b, 16'h0000);
        wr(6'h28, 16'h1234);
        wr(6'h29, 16'h5678);
        wr(6'h25, 16'h8205);
        idle(5);
        check(acc, 32'h1234_5678);
        wr(6'h25, 16'h0205);
        idle(5);
        check(acc, 32'h0000_0000);
        wr(6'h1e, 16'h18a6);
        wr(6'h00, 16'h0002);
        rd(6'h1f, 16'hc3e6);
        rd(6'h20, 16'h05bf);
        rd(6'h21, 16'h1e01);
        rd(6'h23, 16'h0004);
        rd(6'h1e, 16'h18a6);
        rd(6'h22, pat(6'h22));
        rd(6'h00, 16'h0000);
        wr(6'h1f, 16'hc3e6);
        wr(6'h20, 16'h05bf);
        wr(6'h21, 16'h1e01);
        wr(6'h23, 16'h0004);
        wr(6'h22, 16'h0015);
        rd(6'h22, 16'h0015);
        check(32'(fdiv), 32'({3'b101, pat(6'h24)}));
        // Ratio 3/4: any four steady cycles give three carries
        wr(6'h26, 16'h0000);
        wr(6'h27, 16'h0004);
        wr(6'h2b, 16'h0003);
        idle(4);
        repeat (4) begin
            @(posedge core_clk_i);
            #1;
            win_acc += acc;
            win_carry += 32'(carry);
        end
        check(win_acc, 32'h0000_0006);
        check(win_carry, 32'h0000_0003);
        do_reset();
        rd(6'h24, 16'h0028);
        check(acc, 32'h0000_0000);
        print_verdict();
    end
endmodule : synth_divider_config_regs_test
